// *** include/wwd_pkg.sv ***
// Package for the window watchdog: option byte layout, register offsets,
// key value, reset values and timing constants.
// Assumes a single 125 MHz ref_clk; the low-speed oscillator is an enable pulse.
package wwd_pkg;

   // Reference clock and low-speed oscillator
   localparam int REF_CLK_KHZ = 125000;
   localparam int LS_OSC_KHZ = 15;
   localparam int LS_DIV_CYCLES = REF_CLK_KHZ / LS_OSC_KHZ;

   // Register map on the plain port
   localparam logic [19:0] OPTION_BYTE_ADDR = 20'h000C0;
   localparam logic [19:0] OPTION_BYTE_SWAP_ADDR = 20'h010C0;
   localparam logic [19:0] RESTART_KEY_ADDR = 20'hFFFAB;
   localparam logic [19:0] SPEED_MODE_CTRL_ADDR = 20'hFFFF3;
   localparam logic [19:0] RESET_CAUSE_ADDR = 20'hFFFA8;
   localparam logic [19:0] COUNTER_ADDR = 20'hFFFAC;

   localparam logic [7:0] RESTART_KEY_VALUE = 8'hAC;
   localparam logic [7:0] RESET_CAUSE_RESET = 8'h00;
   localparam logic [7:0] SPEED_MODE_RESET = 8'h00;

   // Option byte field positions, plus speed mode and reset cause bit positions
   localparam int OPT_IRQ_EN_BIT = 7;
   localparam int OPT_WIN_HI_BIT = 6;
   localparam int OPT_WIN_LO_BIT = 5;
   localparam int OPT_CNT_EN_BIT = 4;
   localparam int OPT_OVF_HI_BIT = 3;
   localparam int OPT_OVF_LO_BIT = 1;
   localparam int OPT_STBY_RUN_BIT = 0;
   localparam int SMC_LS_SEL_BIT = 4;
   localparam int WDT_FLAG_BIT = 4;

   localparam int CNT_WIDTH = 17;

   typedef struct packed {
      logic interval_irq_enable;
      logic window_sel_hi;
      logic window_sel_lo;
      logic counter_enable_cfg;
      logic [2:0] overflow_sel;
      logic standby_run_cfg;
   } wwd_cfg_type;

   typedef struct packed {
      logic [19:0] addr;
      logic [7:0] wrData;
      logic wrStrobe;
      logic rdStrobe;
      logic bitAccess;
   } wwd_bus_type;

   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_RUN = 3'b010,
      ST_STOP = 3'b100
   } wwd_state_type;

endpackage

// *** design/wwd_window_watchdog.sv ***
// Window watchdog: counter on the low-speed oscillator enable, option byte
// fetch at reset release, restart key checks and reset cause flag.
// Assumes optByteData holds the flash byte at optByteAddr combinationally.
//
// Contract
// R1 - Counter advances only on low-speed oscillator ticks, about 15 kHz.
// R2 - Oscillator runs when counter enable or low-speed clock select is set.
// R3 - Standby with select 0, enabled, standby run 0 stops oscillator and counter.
// R4 - After standby release oscillator restarts and counter resumes from zero.
// R5 - Standby run bit 0 forces a 100 percent open window.
// R6 - Enabled with standby run 1 keeps oscillator and counter going in standby.
// R7 - Software wakes periodically to restart the watchdog when it runs in standby.
// R8 - Counter overflow before a valid restart causes an internal reset.
// R9 - A single-bit access to the restart key register causes a reset.
// R10 - Writing anything but ACH to the restart key register causes a reset.
// R11 - Any key write while the window is closed causes a reset.
// R12 - Watchdog reset clears the counter to zero.
// R13 - Watchdog reset sets bit 4 of the reset cause register.
// R14 - Option byte is read automatically at reset release and applied.
// R15 - With boot swap the option byte comes from 010C0H instead of 000C0H.
// R16 - Option byte bits: irq enable, window select, enable, overflow select, standby run.
// R17 - Interval interrupt at 75 percent of overflow when enabled.
// R18 - Window codes 01, 10, 11 give 50, 75, 100 percent; 00 prohibited.
// R19 - Counter starts right after reset when enabled, otherwise stays stopped.
// R20 - Overflow codes select 2^6,7,8,9,11,13,14,16 oscillator cycles.
// R21 - First restart after reset is accepted anywhere before overflow.
// R22 - Window is the last fraction of the period; valid key clears counter.
// R23 - Reset release clears counter and interrupt state.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps

module wwd_window_watchdog #(
   parameter int LS_DIV = wwd_pkg::LS_DIV_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic bootSwap,
   input wire logic standbyReq,
   input wire logic [7:0] optByteData,
   output logic [19:0] optByteAddr,
   input wire logic [19:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWrStrobe,
   input wire logic busRdStrobe,
   input wire logic busBitAccess,
   output logic [7:0] busRdData,
   output logic intervalIrq,
   output logic wdtReset,
   output logic lsOscRun
);

   //////////////////////////////////////////////////////////////////////////
   // Decoding helpers

   function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
      case (sel)
         3'h0: ovf_exp = 5'h06;
         3'h1: ovf_exp = 5'h07;
         3'h2: ovf_exp = 5'h08;
         3'h3: ovf_exp = 5'h09;
         3'h4: ovf_exp = 5'h0B;
         3'h5: ovf_exp = 5'h0D;
         3'h6: ovf_exp = 5'h0E;
         default: ovf_exp = 5'h10;
      endcase
   endfunction

   function automatic logic [16:0] frac_of(input logic [16:0] period, input logic [1:0] quarters);
      frac_of = 17'((period >> 2) * quarters);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // Declarations

   wwd_pkg::wwd_state_type stateQ;
   wwd_pkg::wwd_cfg_type cfgQ;
   wwd_pkg::wwd_bus_type bus;
   logic [16:0] countQ;
   logic [16:0] period;
   logic [1:0] closedQuarters;
   logic [15:0] divQ;
   logic lsTick;
   logic firstRestartQ;
   logic irqDoneQ;
   // High for the first edge after release, while the fetch address moves to its area
   logic loadWaitQ;
   logic [7:0] speedModeQ;
   logic [7:0] resetCauseQ;
   logic keyWrite;
   logic keyFault;
   logic overflow;
   logic windowOpen;
   logic oscEnable;
   logic stopCounting;

   assign bus = '{addr: busAddr, wrData: busWrData, wrStrobe: busWrStrobe,
                  rdStrobe: busRdStrobe, bitAccess: busBitAccess};

   //////////////////////////////////////////////////////////////////////////
   // Option byte fetch at reset release

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         optByteAddr <= wwd_pkg::OPTION_BYTE_ADDR;
      end else begin
         optByteAddr <= bootSwap ? wwd_pkg::OPTION_BYTE_SWAP_ADDR
                                 : wwd_pkg::OPTION_BYTE_ADDR; // [R15]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfgQ <= '0;
      end else if (stateQ == wwd_pkg::ST_LOAD && !loadWaitQ) begin
         cfgQ <= wwd_pkg::wwd_cfg_type'(optByteData); // [R14] [R16]
      end
   end

   // The fetch address only takes bootSwap at the first edge after release,
   // so the byte is taken one edge later; sampling earlier would always read
   // the primary area even when boot swap is in use.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         loadWaitQ <= 1'b1;
      end else begin
         loadWaitQ <= 1'b0; // [R15]
      end
   end

   // Two cycles in LOAD: address settle, then option byte capture
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stateQ <= wwd_pkg::ST_LOAD;
      end else begin
         case (stateQ)
            wwd_pkg::ST_LOAD: begin
               if (!loadWaitQ) begin
                  stateQ <= wwd_pkg::ST_RUN; // [R19]
               end
            end
            wwd_pkg::ST_RUN: begin
               if (stopCounting) begin
                  stateQ <= wwd_pkg::ST_STOP; // [R3]
               end
            end
            wwd_pkg::ST_STOP: begin
               if (!standbyReq) begin
                  stateQ <= wwd_pkg::ST_RUN; // [R4]
               end
            end
            default: begin
               stateQ <= wwd_pkg::ST_LOAD;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Low-speed oscillator, modelled as a divided enable

   assign stopCounting = standbyReq && cfgQ.counter_enable_cfg && !cfgQ.standby_run_cfg
                         && !speedModeQ[wwd_pkg::SMC_LS_SEL_BIT]; // [R3]
   assign oscEnable = (cfgQ.counter_enable_cfg || speedModeQ[wwd_pkg::SMC_LS_SEL_BIT])
                      && stateQ != wwd_pkg::ST_STOP && stateQ != wwd_pkg::ST_LOAD; // [R2] [R6]

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         divQ <= '0;
      end else if (!oscEnable) begin
         divQ <= '0;
      end else if (divQ == 16'(LS_DIV - 1)) begin
         divQ <= '0;
      end else begin
         divQ <= divQ + 16'h0001;
      end
   end

   assign lsTick = oscEnable && divQ == 16'(LS_DIV - 1); // [R1]

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         lsOscRun <= 1'b0;
      end else begin
         lsOscRun <= oscEnable;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Window and key checks

   assign period = 17'h00001 << ovf_exp(cfgQ.overflow_sel); // [R20]

   // Closed part in quarters: 50% open closes two, 75% open closes one
   always_comb begin
      closedQuarters = 2'h0;
      if (cfgQ.standby_run_cfg) begin // [R5]
         case ({cfgQ.window_sel_hi, cfgQ.window_sel_lo})
            2'b01: closedQuarters = 2'h2; // [R18]
            2'b10: closedQuarters = 2'h1;
            2'b11: closedQuarters = 2'h0;
            default: closedQuarters = 2'h2; // Prohibited code: take the narrowest window
         endcase
      end
   end

   assign windowOpen = firstRestartQ || countQ >= frac_of(period, closedQuarters); // [R21] [R22]
   assign keyWrite = bus.wrStrobe && bus.addr == wwd_pkg::RESTART_KEY_ADDR;
   assign keyFault = keyWrite && (bus.bitAccess // [R9]
                     || bus.wrData != wwd_pkg::RESTART_KEY_VALUE // [R10]
                     || !windowOpen); // [R11]
   assign overflow = lsTick && stateQ == wwd_pkg::ST_RUN && cfgQ.counter_enable_cfg
                     && countQ == period - 17'h00001; // [R8]

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         firstRestartQ <= 1'b1;
      end else if (keyWrite && !keyFault) begin
         firstRestartQ <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Counter

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         countQ <= '0; // [R23]
      end else if (overflow || keyFault) begin
         countQ <= '0; // [R12]
      end else if (keyWrite) begin
         countQ <= '0; // [R22]
      end else if (stateQ == wwd_pkg::ST_STOP) begin
         countQ <= '0; // [R4]
      end else if (lsTick && stateQ == wwd_pkg::ST_RUN && cfgQ.counter_enable_cfg) begin
         countQ <= countQ + 17'h00001; // [R19]
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Interval interrupt and internal reset

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         intervalIrq <= 1'b0;
         irqDoneQ <= 1'b0; // [R23]
      end else begin
         intervalIrq <= 1'b0;
         if (keyWrite || overflow || stateQ == wwd_pkg::ST_STOP) begin
            irqDoneQ <= 1'b0;
         end else if (cfgQ.interval_irq_enable && !irqDoneQ
                      && countQ >= frac_of(period, 2'h3)) begin
            intervalIrq <= 1'b1; // [R17]
            irqDoneQ <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wdtReset <= 1'b0;
      end else begin
         wdtReset <= overflow || keyFault; // [R8] [R9] [R10] [R11]
      end
   end

   // The flag lives outside the reset it reports; only a read or rst_b clears it
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         resetCauseQ <= wwd_pkg::RESET_CAUSE_RESET;
      end else if (overflow || keyFault) begin
         resetCauseQ[wwd_pkg::WDT_FLAG_BIT] <= 1'b1; // [R13]
      end else if (bus.rdStrobe && bus.addr == wwd_pkg::RESET_CAUSE_ADDR) begin
         resetCauseQ <= '0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register port

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         speedModeQ <= wwd_pkg::SPEED_MODE_RESET;
      end else if (bus.wrStrobe && bus.addr == wwd_pkg::SPEED_MODE_CTRL_ADDR) begin
         speedModeQ <= bus.wrData;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         busRdData <= '0;
      end else if (bus.rdStrobe) begin
         case (bus.addr)
            wwd_pkg::RESET_CAUSE_ADDR: busRdData <= resetCauseQ;
            wwd_pkg::SPEED_MODE_CTRL_ADDR: busRdData <= speedModeQ;
            wwd_pkg::RESTART_KEY_ADDR: busRdData <= firstRestartQ ? 8'h9A : 8'h9B;
            wwd_pkg::COUNTER_ADDR: busRdData <= countQ[16:9];
            wwd_pkg::OPTION_BYTE_ADDR: busRdData <= cfgQ;
            default: busRdData <= 8'h00;
         endcase
      end else begin
         busRdData <= 8'h00;
      end
   end

endmodule

// *** sim/wwd_window_watchdog_monitor.sv ***
// Port checker for the window watchdog.
// Bound to the top module; one clock, async reset rst_b.
`timescale 1ns/100ps
module wwd_window_watchdog_monitor (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic bootSwap,
   input wire logic standbyReq,
   input wire logic [7:0] optByteData,
   input wire logic [19:0] optByteAddr,
   input wire logic [19:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWrStrobe,
   input wire logic busRdStrobe,
   input wire logic busBitAccess,
   input wire logic [7:0] busRdData,
   input wire logic intervalIrq,
   input wire logic wdtReset,
   input wire logic lsOscRun
);
   logic keyWr;
   logic causeRd;
   logic flagHeld_q;
   assign keyWr = busWrStrobe && busAddr == wwd_pkg::RESTART_KEY_ADDR;
   assign causeRd = busRdStrobe && busAddr == wwd_pkg::RESET_CAUSE_ADDR;
   // Flag owed to software from a reset pulse until its next read
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flagHeld_q <= 1'b0;
      end else if (wdtReset) begin
         flagHeld_q <= 1'b1;
      end else if (causeRd) begin
         flagHeld_q <= 1'b0;
      end
   end
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_reset_one_cycle: assert property (wdtReset && !keyWr |=> !wdtReset)
      else $error("reset pulse too long");
   a_irq_one_cycle: assert property (intervalIrq |=> !intervalIrq)
      else $error("irq pulse too long");
   a_bad_key_reset: assert property (keyWr && busWrData != wwd_pkg::RESTART_KEY_VALUE |=> wdtReset)
      else $error("bad key without reset");
   a_bit_key_reset: assert property (keyWr && busBitAccess |=> wdtReset)
      else $error("bit access without reset");
   a_read_idle_zero: assert property (!busRdStrobe |=> busRdData == 8'h00)
      else $error("read data outside slot");
   a_flag_read_set: assert property (causeRd && flagHeld_q |=> busRdData[4])
      else $error("reset flag missing");
   a_cause_other_bits: assert property (causeRd |=> (busRdData & 8'hEF) == 8'h00)
      else $error("cause bits besides flag");
   a_release_quiet: assert property ($rose(rst_b) |-> !wdtReset && !intervalIrq)
      else $error("pulse at reset release");
   a_fetch_addr_swap: assert property (!$rose(rst_b) |-> optByteAddr ==
      ($past(bootSwap) ? wwd_pkg::OPTION_BYTE_SWAP_ADDR : wwd_pkg::OPTION_BYTE_ADDR))
      else $error("option fetch address");
endmodule

// *** sim/wwd_window_watchdog_tb.sv ***
// Self-checking bench for the window watchdog, register port driven directly.
// Assumes the option byte flash is modelled here from optByteAddr.
`timescale 1ns/100ps
module wwd_window_watchdog_tb;
   localparam int LS = 4;
   localparam logic [19:0] KEY = wwd_pkg::RESTART_KEY_ADDR;
   localparam logic [19:0] CAUSE = wwd_pkg::RESET_CAUSE_ADDR;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic bootSwap = 1'b0;
   logic standbyReq = 1'b0;
   logic [7:0] optMain = 8'hB1;
   logic [7:0] optSwap = 8'hB2;
   logic [7:0] optByteData;
   logic [19:0] optByteAddr;
   logic [19:0] busAddr = 20'h00000;
   logic [7:0] busWrData = 8'h00;
   logic busWrStrobe = 1'b0;
   logic busRdStrobe = 1'b0;
   logic busBitAccess = 1'b0;
   logic [7:0] busRdData;
   logic intervalIrq;
   logic wdtReset;
   logic lsOscRun;
   int fail_count = 0;
   int compares = 0;
   int rstSeen = 0;
   int held;
   always #4 ref_clk = ~ref_clk;
   // Swap area holds a different byte so a wrong fetch shows
   assign optByteData = optByteAddr == wwd_pkg::OPTION_BYTE_SWAP_ADDR ? optSwap : optMain;
   always @(posedge ref_clk) if (wdtReset === 1'b1) rstSeen++;
   wwd_window_watchdog #(.LS_DIV(LS)) i_wwd_window_watchdog (.ref_clk, .rst_b, .bootSwap,
      .standbyReq, .optByteData, .optByteAddr, .busAddr, .busWrData, .busWrStrobe,
      .busRdStrobe, .busBitAccess, .busRdData, .intervalIrq, .wdtReset, .lsOscRun);
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic doReset(input logic swap);
      bootSwap <= swap;
      rst_b <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b, input logic r);
      @(posedge ref_clk);
      busAddr <= a;
      busWrData <= d;
      busBitAccess <= b;
      busWrStrobe <= 1'b1;
      @(posedge ref_clk);
      busWrStrobe <= 1'b0;
      busBitAccess <= 1'b0;
      #1 chk(8'(wdtReset), 8'(r));
   endtask
   task automatic rd(input logic [19:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      busAddr <= a;
      busRdStrobe <= 1'b1;
      @(posedge ref_clk);
      busRdStrobe <= 1'b0;
      #1 chk(busRdData, e);
   endtask
   // Tick phase is free running, so timings get a few cycles of slack
   task automatic waitEv(input int per);
      int n;
      int irqAt;
      n = 0;
      irqAt = 0;
      @(posedge ref_clk);
      while (n < per * LS + 40 && wdtReset !== 1'b1) begin
         @(posedge ref_clk);
         #1 n++;
         if (intervalIrq === 1'b1) irqAt = n;
      end
      chk(8'((n - per * LS) inside {[-8:8]}), 8'h01);
      chk(8'((irqAt - per * LS * 3 / 4) inside {[-8:8]}), 8'h01);
   endtask
   task automatic waitSig(input logic irq, input logic e);
      int k;
      for (k = 0; k < 600 && (irq ? intervalIrq : lsOscRun) !== e; k++) @(posedge ref_clk);
      #1 chk(8'(k < 600), 8'h01);
   endtask
   task automatic wrap_up;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      doReset(1'b0);
      rd(wwd_pkg::OPTION_BYTE_ADDR, 8'hB1);
      rd(CAUSE, 8'h00);
      rd(20'h12345, 8'h00);
      chk(8'(lsOscRun), 8'h01);
      wr(KEY, 8'hAC, 1'b0, 1'b0);
      wr(KEY, 8'hAC, 1'b0, 1'b1);
      rd(CAUSE, 8'h10);
      rd(CAUSE, 8'h00);
      wr(KEY, 8'h5A, 1'b0, 1'b1);
      wr(KEY, 8'hAC, 1'b1, 1'b1);
      @(posedge ref_clk) standbyReq <= 1'b1;
      waitEv(64);
      chk(8'(lsOscRun), 8'h01);
      @(posedge ref_clk) standbyReq <= 1'b0;
      waitSig(1'b1, 1'b1);
      wr(KEY, 8'hAC, 1'b0, 1'b0);
      waitEv(64);
      $display("test config main done");
      doReset(1'b1);
      rd(wwd_pkg::OPTION_BYTE_ADDR, 8'hB2);
      wr(KEY, 8'hAC, 1'b0, 1'b0);
      wr(KEY, 8'hAC, 1'b0, 1'b0);
      @(posedge ref_clk) standbyReq <= 1'b1;
      waitSig(1'b0, 1'b0);
      held = rstSeen;
      repeat (600) @(posedge ref_clk);
      chk(8'(rstSeen - held), 8'h00);
      @(posedge ref_clk) standbyReq <= 1'b0;
      waitSig(1'b0, 1'b1);
      waitEv(128);
      $display("test swap and standby done");
      optMain <= 8'h20;
      doReset(1'b0);
      chk(8'(lsOscRun), 8'h00);
      wr(wwd_pkg::SPEED_MODE_CTRL_ADDR, 8'h10, 1'b0, 1'b0);
      waitSig(1'b0, 1'b1);
      rd(wwd_pkg::SPEED_MODE_CTRL_ADDR, 8'h10);
      held = rstSeen;
      repeat (600) @(posedge ref_clk);
      chk(8'(rstSeen - held), 8'h00);
      $display("test counter disabled done");
      wrap_up;
   end
   initial begin
      #100000;
      fail_count++;
      wrap_up;
   end
endmodule
bind wwd_window_watchdog wwd_window_watchdog_monitor i_wwd_window_watchdog_monitor (.ref_clk,
   .rst_b, .bootSwap, .standbyReq, .optByteData, .optByteAddr, .busAddr, .busWrData,
   .busWrStrobe, .busRdStrobe, .busBitAccess, .busRdData, .intervalIrq, .wdtReset, .lsOscRun);
